// ===== src/jms_pkg.sv
// constants, types and helpers shared by the jog mode sequencer
// Behaviour
// - activate-mode input configured: start only on rising edge
// - mode change accepted once active mode terminated
// - moving: change only among jog, torque, velocity, position
// - into jog needs standstill; torque/velocity switch at once
// - into position follows change type; strict profile needs zero
// - standstill for change uses the halt ramp setting
// - jog from actual position, two methods, two speeds
// - continuous method moves while direction request held
// - short step request moves step distance then stops
// - held step request: step, pause, then continuous
// - local control starts selected mode on power enable
// - default inputs: enable, fault reset, jog neg, jog pos
// - fieldbus control: jog-with-enable input enables, changes a non-jog mode to jog, moves direction
// - fieldbus control: opmode write activates mode; jog request starts movement
// - jog request bits: positive, negative, fast; values 0..7
// - status bits 10 and 12 reserved while jogging
// - jog ends at standstill with no request or stop
// - step pause in ms 1..32767, default 500, next movement
// - method 0 continuous, 1 step, separate input and bus
package jms_pkg;

	// parameter addresses
	localparam logic [15:0] JMS_ADDR_OPMODE_SELECT   = 16'h1b00;
	localparam logic [15:0] JMS_ADDR_ACTIVE_MODE     = 16'h1b02;
	localparam logic [15:0] JMS_ADDR_INPUT_JOG_METH  = 16'h1b04;
	localparam logic [15:0] JMS_ADDR_BUS_JOG_METH    = 16'h1b06;
	localparam logic [15:0] JMS_ADDR_STEP_DISTANCE   = 16'h1b08;
	localparam logic [15:0] JMS_ADDR_STEP_PAUSE_TIME = 16'h1b0a;
	localparam logic [15:0] JMS_ADDR_HALT_RAMP_SEL   = 16'h1b0c;
	localparam logic [15:0] JMS_ADDR_POS_CHG_TYPE    = 16'h1b0e;
	localparam logic [15:0] JMS_ADDR_INPUT_MAP       = 16'h1b10;
	localparam logic [15:0] JMS_ADDR_JOG_REQUEST     = 16'h1b12;
	localparam logic [15:0] JMS_ADDR_JOG_STATUS      = 16'h1b14;

	// reset values
	localparam logic [15:0] JMS_RST_OPMODE     = 16'h0000;
	localparam logic        JMS_RST_METHOD     = 1'b0;
	localparam logic [31:0] JMS_RST_STEP_DIST  = 32'h0000_0014;
	localparam logic [14:0] JMS_RST_PAUSE_MS   = 15'h01f4;
	localparam logic [15:0] JMS_RST_HALT_RAMP  = 16'h0000;
	localparam logic [15:0] JMS_RST_CHG_TYPE   = 16'h0000;
	localparam logic [15:0] JMS_RST_INPUT_MAP  = 16'h4321;
	localparam logic [2:0]  JMS_RST_JOG_REQ    = 3'h0;

	// limits
	localparam logic [31:0] JMS_JOG_REQ_MAX    = 32'h0000_0007;
	localparam logic [31:0] JMS_PAUSE_MIN      = 32'h0000_0001;
	localparam logic [31:0] JMS_PAUSE_MAX      = 32'h0000_7fff;
	localparam logic [31:0] JMS_STEP_DIST_MIN  = 32'h0000_0001;
	localparam logic [31:0] JMS_STEP_DIST_MAX  = 32'h7fff_ffff;

	// jog request fields
	localparam int JMS_JR_POS  = 0;
	localparam int JMS_JR_NEG  = 1;
	localparam int JMS_JR_FAST = 2;

	// status word reserved positions during jog
	localparam int JMS_SW_RSV_A = 10;
	localparam int JMS_SW_RSV_B = 12;

	// operating mode codes
	localparam logic [15:0] JMS_MODE_JOG = 16'hffff;
	localparam logic [15:0] JMS_MODE_PP  = 16'h0001;
	localparam logic [15:0] JMS_MODE_PV  = 16'h0003;
	localparam logic [15:0] JMS_MODE_PT  = 16'h0004;

	// input function codes, four bits per pin in the input map
	localparam logic [3:0] JMS_FN_NONE     = 4'h0;
	localparam logic [3:0] JMS_FN_ENABLE   = 4'h1;
	localparam logic [3:0] JMS_FN_FAULT    = 4'h2;
	localparam logic [3:0] JMS_FN_JOG_NEG  = 4'h3;
	localparam logic [3:0] JMS_FN_JOG_POS  = 4'h4;
	localparam logic [3:0] JMS_FN_POS_EN   = 4'h5;
	localparam logic [3:0] JMS_FN_NEG_EN   = 4'h6;
	localparam logic [3:0] JMS_FN_ACTIVATE = 4'h7;
	localparam logic [3:0] JMS_FN_FAST     = 4'h8;

	// timing
	localparam int unsigned JMS_CLOCK_HZ     = 50_000_000;
	localparam int unsigned JMS_PAUSE_UNIT_MS = 1;
	localparam int unsigned JMS_CYCLES_PER_MS = JMS_CLOCK_HZ / 1000 * JMS_PAUSE_UNIT_MS;

	typedef enum logic [2:0] {
		JMS_READY,
		JMS_CONT,
		JMS_STEP,
		JMS_PAUSE,
		JMS_STOP
	} jms_jog_state_t;

	// parameter access from the fieldbus side
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} jms_param_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} jms_param_rsp_t;

	// command toward the motion and power stage
	typedef struct packed {
		logic        move;
		logic        dir_neg;
		logic        fast;
		logic        step;
		logic [31:0] distance;
		logic        halt;
		logic [15:0] halt_ramp;
	} jms_motion_t;

	function automatic logic jms_in_group(input logic [15:0] m);
		return (m == JMS_MODE_JOG) || (m == JMS_MODE_PP) ||
			(m == JMS_MODE_PV) || (m == JMS_MODE_PT);
	endfunction

endpackage

// ===== src/jms_rise_detect.sv
// rising edge detector for a group of synchronous levels
`timescale 1ns/100ps
`default_nettype none
module jms_rise_detect
	import jms_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clock,   // drive clock
	input  wire logic         reset_n, // async reset, low
	input  wire logic [W-1:0] level,   // levels to watch
	output logic      [W-1:0] rise     // one cycle on 0 to 1
);
	typedef struct packed {
		logic [W-1:0] prev;
	} jms_rise_state_t;

	jms_rise_state_t s;
	jms_rise_state_t next_s;

	// remember last level
	always_comb begin
		next_s = s;
		next_s.prev = level;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rise = level & ~s.prev;
endmodule
`default_nettype wire

// ===== src/jms_pause_timer.sv
// millisecond pause timer for step movements
`timescale 1ns/100ps
`default_nettype none
module jms_pause_timer
	import jms_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = JMS_CYCLES_PER_MS
) (
	input  wire logic        clock,    // drive clock
	input  wire logic        reset_n,  // async reset, low
	input  wire logic        start,    // pulse, loads pause
	input  wire logic        cancel,   // abandons a running pause
	input  wire logic [14:0] pause_ms, // pause length in ms
	output logic             done      // one cycle at expiry
);
	typedef struct packed {
		logic [15:0] cyc;
		logic [14:0] ms;
		logic        busy;
		logic        done;
	} jms_timer_state_t;

	localparam logic [15:0] LAST_CYC = 16'(CYCLES_PER_MS - 1);

	jms_timer_state_t s;
	jms_timer_state_t next_s;

	// count whole milliseconds; a zero pause still waits one ms
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (start) begin
			next_s.busy = 1'b1;
			next_s.cyc = '0;
			next_s.ms = (pause_ms == '0) ? 15'h0001 : pause_ms;
		end else if (cancel) begin
			next_s.busy = 1'b0;
		end else if (s.busy) begin
			if (s.cyc == LAST_CYC) begin
				next_s.cyc = '0;
				next_s.ms = s.ms - 15'h0001;
				if (s.ms == 15'h0001) begin
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end
			end else begin
				next_s.cyc = s.cyc + 16'h0001;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;
endmodule
`default_nettype wire

// ===== src/jms_jog_mode_sequencer.sv
// jog mode sequencer: mode start, mode change and jog movements
`timescale 1ns/100ps
`default_nettype none
module jms_jog_mode_sequencer
	import jms_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = JMS_CYCLES_PER_MS
) (
	input  wire logic           clock,            // drive clock, 50 MHz
	input  wire logic           reset_n,          // async reset, low
	input  wire jms_param_req_t param_req,        // parameter access
	output jms_param_rsp_t      param_rsp,        // parameter answer
	input  wire logic [3:0]     input_pins,       // digital inputs 0..3
	input  wire logic           fieldbus_control, // 1 fieldbus, 0 local
	input  wire logic           bus_power_enable, // power request from bus
	input  wire logic           ds402_profile,    // strict drive profile
	input  wire logic           standstill,       // motor at rest
	input  wire logic           step_done,        // step distance reached
	input  wire logic           halt_in,          // halt occurred
	input  wire logic           quick_stop_in,    // quick stop occurred
	input  wire logic           error_in,         // error detected
	input  wire logic [15:0]    status_word_in,   // common status word
	output logic                power_enable,     // power stage on
	output logic                fault_reset,      // pulse, clear error
	output jms_motion_t         motion,           // motion command
	output logic [15:0]         active_mode,      // running mode code
	output logic                jog_active,       // jog mode started
	output logic [15:0]         status_word       // status word out
);
	typedef struct packed {
		logic [15:0]    opmode_sel;
		logic [15:0]    active_mode;
		logic [15:0]    pending_mode;
		logic           change_req;
		logic           started;
		logic           power_enable;
		logic           input_method;
		logic           bus_method;
		logic [31:0]    step_distance;
		logic [14:0]    pause_ms;
		logic [15:0]    halt_ramp;
		logic [15:0]    chg_type;
		logic [15:0]    input_map;
		logic [2:0]     jog_req;
		jms_jog_state_t jog;
		logic           dir_neg;
		logic           run_step;
		logic [14:0]    run_pause;
		jms_motion_t    motion;
		jms_param_rsp_t rsp;
		logic [15:0]    status_word;
		logic           fault_reset;
		logic           jog_active;
	} jms_state_t;

	jms_state_t  s;
	jms_state_t  next_s;
	logic [15:0] fn;
	logic [1:0]  rise;
	logic        pause_start;
	logic        pause_cancel;
	logic        pause_done;

	// input functions from the pin map; all pins reassignable
	always_comb begin
		fn = '0;
		for (int i = 0; i < 4; i++) begin
			fn[s.input_map[i*4 +: 4]] = fn[s.input_map[i*4 +: 4]] | input_pins[i];
		end
	end

	jms_rise_detect #(
		.W (2)
	) u_rise (
		.clock   (clock),
		.reset_n (reset_n),
		.level   ({fn[JMS_FN_FAULT], fn[JMS_FN_ACTIVATE]}),
		.rise    (rise)
	);

	jms_pause_timer #(
		.CYCLES_PER_MS (CYCLES_PER_MS)
	) u_pause (
		.clock    (clock),
		.reset_n  (reset_n),
		.start    (pause_start),
		.cancel   (pause_cancel),
		.pause_ms (s.run_pause),
		.done     (pause_done)
	);

	// pause runs only in its own state
	assign pause_start = (s.jog != JMS_PAUSE) && (next_s.jog == JMS_PAUSE);
	assign pause_cancel = (s.jog == JMS_PAUSE) && (next_s.jog != JMS_PAUSE);

	// activate pin counts as configured when any pin carries it
	logic act_cfg;
	always_comb begin
		act_cfg = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (s.input_map[i*4 +: 4] == JMS_FN_ACTIVATE) begin
				act_cfg = 1'b1;
			end
		end
	end

	// sequencer next state
	always_comb begin
		logic req_pos;
		logic req_neg;
		logic req_fast;
		logic req_step;
		logic want_power;
		logic en_jog_in;
		logic one_dir;
		logic stop_evt;
		logic need_still;
		logic jog_run;
		logic terminated;
		logic [31:0] wd;
		req_pos = 1'b0;
		req_neg = 1'b0;
		req_fast = 1'b0;
		req_step = 1'b0;
		want_power = 1'b0;
		need_still = 1'b0;
		wd = param_req.wdata;
		en_jog_in = fn[JMS_FN_POS_EN] | fn[JMS_FN_NEG_EN];
		stop_evt = halt_in | quick_stop_in | error_in;
		next_s = s;
		next_s.rsp.ack = 1'b0;
		next_s.rsp.err = 1'b0;
		next_s.fault_reset = rise[1];
		next_s.motion.halt = 1'b0;

		// request source by control mode
		if (!fieldbus_control) begin
			req_pos = fn[JMS_FN_JOG_POS];
			req_neg = fn[JMS_FN_JOG_NEG];
			req_fast = fn[JMS_FN_FAST];
			req_step = s.input_method;
			want_power = fn[JMS_FN_ENABLE];
		end else if (en_jog_in) begin
			req_pos = fn[JMS_FN_POS_EN];
			req_neg = fn[JMS_FN_NEG_EN];
			req_fast = fn[JMS_FN_FAST];
			req_step = s.input_method;
			want_power = 1'b1;
		end else begin
			req_pos = s.jog_req[JMS_JR_POS];
			req_neg = s.jog_req[JMS_JR_NEG];
			req_fast = s.jog_req[JMS_JR_FAST];
			req_step = s.bus_method;
			want_power = bus_power_enable;
		end
		// both directions at once cancel each other
		one_dir = req_pos ^ req_neg;
		next_s.power_enable = want_power & ~error_in;

		// mode start
		if (!next_s.power_enable) begin
			next_s.started = s.started && !standstill;
		end else if (!fieldbus_control) begin
			if (!act_cfg && !s.power_enable) begin
				next_s.started = 1'b1;
				next_s.active_mode = s.opmode_sel;
			end else if (act_cfg && rise[0]) begin
				next_s.started = 1'b1;
				next_s.active_mode = s.opmode_sel;
			end
		end else if (en_jog_in && s.active_mode != JMS_MODE_JOG) begin
			next_s.change_req = 1'b1;
			next_s.pending_mode = JMS_MODE_JOG;
		end

		// mode change: group members may switch while moving
		terminated = (s.jog == JMS_READY) && standstill;
		if (s.change_req) begin
			if (s.pending_mode == JMS_MODE_JOG) begin
				need_still = 1'b1;
			end else if (s.pending_mode == JMS_MODE_PP) begin
				need_still = ds402_profile || (s.chg_type == '0);
			end
			if (terminated || (s.active_mode != JMS_MODE_JOG && standstill)) begin
				next_s.active_mode = s.pending_mode;
				next_s.change_req = 1'b0;
				next_s.started = next_s.power_enable;
			end else if (jms_in_group(s.active_mode) && jms_in_group(s.pending_mode)) begin
				if (need_still) begin
					next_s.motion.halt = 1'b1;
				end else begin
					next_s.active_mode = s.pending_mode;
					next_s.change_req = 1'b0;
					next_s.started = next_s.power_enable;
				end
			end
			// other targets wait here until the motor rests
		end

		// jog movement
		jog_run = next_s.started && (next_s.active_mode == JMS_MODE_JOG) && !next_s.motion.halt;
		if (!jog_run || stop_evt || !next_s.power_enable) begin
			next_s.motion.move = 1'b0;
			next_s.motion.step = 1'b0;
			next_s.jog = (s.jog == JMS_READY && standstill) ? JMS_READY : JMS_STOP;
		end else begin
			case (s.jog)
				JMS_READY: begin
					if (one_dir) begin
						// settings latched here apply from this movement on
						next_s.dir_neg = req_neg;
						next_s.run_step = req_step;
						next_s.run_pause = s.pause_ms;
						next_s.motion.dir_neg = req_neg;
						next_s.motion.fast = req_fast;
						next_s.motion.move = 1'b1;
						next_s.motion.distance = s.step_distance;
						next_s.motion.step = req_step;
						next_s.jog = req_step ? JMS_STEP : JMS_CONT;
					end
				end
				JMS_CONT: begin
					next_s.motion.fast = req_fast;
					if (!one_dir || (req_neg != s.dir_neg)) begin
						next_s.motion.move = 1'b0;
						next_s.jog = JMS_STOP;
					end
				end
				JMS_STEP: begin
					next_s.motion.fast = req_fast;
					if (step_done) begin
						next_s.motion.move = 1'b0;
						next_s.motion.step = 1'b0;
						if (one_dir && (req_neg == s.dir_neg)) begin
							next_s.jog = JMS_PAUSE;
						end else begin
							next_s.jog = JMS_STOP;
						end
					end else if (req_pos && req_neg) begin
						next_s.motion.move = 1'b0;
						next_s.motion.step = 1'b0;
						next_s.jog = JMS_STOP;
					end
				end
				JMS_PAUSE: begin
					if (!one_dir || (req_neg != s.dir_neg)) begin
						next_s.jog = JMS_STOP;
					end else if (pause_done) begin
						next_s.motion.move = 1'b1;
						next_s.motion.fast = req_fast;
						next_s.jog = JMS_CONT;
					end
				end
				default: begin
					next_s.motion.move = 1'b0;
					next_s.motion.step = 1'b0;
					if (standstill) begin
						next_s.jog = JMS_READY;
					end
				end
			endcase
		end
		// any stop also ramps down on the halt ramp
		if (next_s.jog == JMS_STOP) begin
			next_s.motion.halt = 1'b1;
		end
		next_s.motion.halt_ramp = s.halt_ramp;

		// status word, mode bits carry nothing while jogging
		next_s.status_word = status_word_in;
		next_s.jog_active = next_s.started && (next_s.active_mode == JMS_MODE_JOG);
		if (next_s.jog_active) begin
			next_s.status_word[JMS_SW_RSV_A] = 1'b0;
			next_s.status_word[JMS_SW_RSV_B] = 1'b0;
		end

		// parameter access, answered one cycle later
		if (param_req.wr) begin
			next_s.rsp.ack = 1'b1;
			if (param_req.addr == JMS_ADDR_OPMODE_SELECT) begin
				next_s.opmode_sel = wd[15:0];
				if (fieldbus_control) begin
					next_s.pending_mode = wd[15:0];
					next_s.change_req = 1'b1;
				end
			end else if (param_req.addr == JMS_ADDR_INPUT_JOG_METH && wd <= 32'h0000_0001) begin
				next_s.input_method = wd[0];
			end else if (param_req.addr == JMS_ADDR_BUS_JOG_METH && wd <= 32'h0000_0001) begin
				next_s.bus_method = wd[0];
			end else if (param_req.addr == JMS_ADDR_STEP_DISTANCE && wd >= JMS_STEP_DIST_MIN &&
				wd <= JMS_STEP_DIST_MAX) begin
				next_s.step_distance = wd;
			end else if (param_req.addr == JMS_ADDR_STEP_PAUSE_TIME && wd >= JMS_PAUSE_MIN &&
				wd <= JMS_PAUSE_MAX) begin
				next_s.pause_ms = wd[14:0];
			end else if (param_req.addr == JMS_ADDR_HALT_RAMP_SEL) begin
				next_s.halt_ramp = wd[15:0];
			end else if (param_req.addr == JMS_ADDR_POS_CHG_TYPE &&
				!(ds402_profile && wd[15:0] != '0)) begin
				next_s.chg_type = wd[15:0];
			end else if (param_req.addr == JMS_ADDR_INPUT_MAP) begin
				next_s.input_map = wd[15:0];
			end else if (param_req.addr == JMS_ADDR_JOG_REQUEST && wd <= JMS_JOG_REQ_MAX) begin
				next_s.jog_req = wd[2:0];
			end else begin
				next_s.rsp.err = 1'b1;
			end
		end else if (param_req.rd) begin
			next_s.rsp.ack = 1'b1;
			next_s.rsp.rdata = '0;
			if (param_req.addr == JMS_ADDR_OPMODE_SELECT) begin
				next_s.rsp.rdata[15:0] = s.opmode_sel;
			end else if (param_req.addr == JMS_ADDR_ACTIVE_MODE) begin
				next_s.rsp.rdata[15:0] = s.active_mode;
			end else if (param_req.addr == JMS_ADDR_INPUT_JOG_METH) begin
				next_s.rsp.rdata[0] = s.input_method;
			end else if (param_req.addr == JMS_ADDR_BUS_JOG_METH) begin
				next_s.rsp.rdata[0] = s.bus_method;
			end else if (param_req.addr == JMS_ADDR_STEP_DISTANCE) begin
				next_s.rsp.rdata = s.step_distance;
			end else if (param_req.addr == JMS_ADDR_STEP_PAUSE_TIME) begin
				next_s.rsp.rdata[14:0] = s.pause_ms;
			end else if (param_req.addr == JMS_ADDR_HALT_RAMP_SEL) begin
				next_s.rsp.rdata[15:0] = s.halt_ramp;
			end else if (param_req.addr == JMS_ADDR_POS_CHG_TYPE) begin
				next_s.rsp.rdata[15:0] = s.chg_type;
			end else if (param_req.addr == JMS_ADDR_INPUT_MAP) begin
				next_s.rsp.rdata[15:0] = s.input_map;
			end else if (param_req.addr == JMS_ADDR_JOG_REQUEST) begin
				next_s.rsp.rdata[2:0] = s.jog_req;
			end else if (param_req.addr == JMS_ADDR_JOG_STATUS) begin
				next_s.rsp.rdata[4:0] = {s.change_req, s.started, 3'(s.jog)};
			end else begin
				next_s.rsp.err = 1'b1;
			end
		end
	end

	// all state in one register; reset gives documented defaults
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
			s.opmode_sel <= JMS_RST_OPMODE;
			s.input_method <= JMS_RST_METHOD;
			s.bus_method <= JMS_RST_METHOD;
			s.step_distance <= JMS_RST_STEP_DIST;
			s.pause_ms <= JMS_RST_PAUSE_MS;
			s.halt_ramp <= JMS_RST_HALT_RAMP;
			s.chg_type <= JMS_RST_CHG_TYPE;
			s.input_map <= JMS_RST_INPUT_MAP;
			s.jog_req <= JMS_RST_JOG_REQ;
			s.jog <= JMS_READY;
		end else begin
			s <= next_s;
		end
	end

	assign param_rsp = s.rsp;
	assign power_enable = s.power_enable;
	assign fault_reset = s.fault_reset;
	assign motion = s.motion;
	assign active_mode = s.active_mode;
	assign jog_active = s.jog_active;
	assign status_word = s.status_word;
endmodule
`default_nettype wire

// ===== tb/jms_props.sv
// assertions on the jog mode sequencer ports
`timescale 1ns/100ps
`default_nettype none
module jms_props
	import jms_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = 4
) (
	input wire logic           clock,         // clock
	input wire logic           reset_n,       // reset
	input wire jms_param_req_t param_req,     // bus in
	input wire jms_param_rsp_t param_rsp,     // bus out
	input wire logic           ds402_profile, // profile
	input wire logic           standstill,    // at rest
	input wire logic           step_done,     // step end
	input wire logic           error_in,      // error
	input wire logic           power_enable,  // power
	input wire logic           fault_reset,   // pulse
	input wire jms_motion_t    motion,        // command
	input wire logic           jog_active,    // jogging
	input wire logic [15:0]    active_mode,   // mode
	input wire logic [15:0]    status_word    // status
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// a refused write names its register and the bad value
	sequence s_bad_wr(a, bad);
		param_req.wr && param_req.addr == a && bad;
	endsequence
	sequence s_step_end;
		motion.move && motion.step && step_done;
	endsequence
	a_jogreq_refused: assert property (s_bad_wr(JMS_ADDR_JOG_REQUEST,
		param_req.wdata > JMS_JOG_REQ_MAX) |=> param_rsp.ack && param_rsp.err)
		else $error("jog request above range accepted");
	a_pause_refused: assert property (s_bad_wr(JMS_ADDR_STEP_PAUSE_TIME,
		param_req.wdata == 0 || param_req.wdata > JMS_PAUSE_MAX) |=> param_rsp.err)
		else $error("pause outside range accepted");
	a_chg_type_zero: assert property (s_bad_wr(JMS_ADDR_POS_CHG_TYPE,
		ds402_profile && param_req.wdata != 0) |=> param_rsp.err)
		else $error("change type accepted under strict profile");
	a_step_then_stop: assert property (s_step_end |=> !motion.move)
		else $error("motion kept after step distance");
	a_status_bits_hidden: assert property (jog_active && $past(jog_active) |->
		!status_word[JMS_SW_RSV_A] && !status_word[JMS_SW_RSV_B])
		else $error("reserved status bits shown while jogging");
	a_end_at_rest: assert property ($fell(jog_active) && active_mode == JMS_MODE_JOG |->
		$past(standstill))
		else $error("jog ended while moving");
	a_fault_one_pulse: assert property ($rose(fault_reset) |=> !fault_reset)
		else $error("fault reset longer than one cycle");
	a_error_no_power: assert property (error_in |=> !power_enable)
		else $error("power kept during error");
endmodule
bind jms_jog_mode_sequencer jms_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (
	.clock(clock), .reset_n(reset_n), .param_req(param_req), .param_rsp(param_rsp),
	.ds402_profile(ds402_profile), .standstill(standstill), .step_done(step_done),
	.error_in(error_in), .power_enable(power_enable), .fault_reset(fault_reset),
	.motion(motion), .jog_active(jog_active), .active_mode(active_mode),
	.status_word(status_word));
`default_nettype wire

// ===== tb/jms_motion_model.sv
// motion stage model answering standstill and step completion
`timescale 1ns/100ps
`default_nettype none
module jms_motion_model
	import jms_pkg::*;
#(
	parameter int LAG = 3
) (
	input  wire logic        clock,      // clock
	input  wire logic        reset_n,    // reset
	input  wire jms_motion_t motion,     // command
	input  wire logic        slow,       // stretch answers
	output logic             standstill, // at rest
	output logic             step_done   // step end
);
	int   cnt;
	int   lim;
	logic mv_q;
	assign lim = slow ? LAG * 4 : LAG;
	// motor rests one cycle after move drops if it moved lim cycles, else it coasts until cnt reaches lim
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			mv_q <= 1'b0;
			standstill <= 1'b1;
			step_done <= 1'b0;
		end else begin
			mv_q <= motion.move;
			cnt <= (motion.move != mv_q) ? 0 : cnt + 1;
			standstill <= !motion.move && (standstill || cnt >= lim);
			step_done <= motion.move && motion.step && cnt == lim;
		end
	end
endmodule
`default_nettype wire

// ===== tb/test_jms_jog_mode_sequencer.sv
// self-checking bench for the jog mode sequencer
`timescale 1ns/100ps
`default_nettype none
module test_jms_jog_mode_sequencer;
	import jms_pkg::*;
	logic           clock, reset_n, fb, bpe, ds4, hlt, qs, err, slow, still, sdone;
	logic           pwr, frst, jact;
	logic [3:0]     pins;
	logic [15:0]    sw_in, amode, sw;
	jms_param_req_t req;
	jms_param_rsp_t rsp;
	jms_motion_t    mo;
	int             bad_count, checks, cycles, seed, i, n, shadow[int];
	jms_jog_mode_sequencer #(.CYCLES_PER_MS(4)) dut (
		.clock(clock), .reset_n(reset_n), .param_req(req), .param_rsp(rsp),
		.input_pins(pins), .fieldbus_control(fb), .bus_power_enable(bpe),
		.ds402_profile(ds4), .standstill(still), .step_done(sdone), .halt_in(hlt),
		.quick_stop_in(qs), .error_in(err), .status_word_in(sw_in), .power_enable(pwr),
		.fault_reset(frst), .motion(mo), .active_mode(amode), .jog_active(jact),
		.status_word(sw));
	jms_motion_model stage (.clock(clock), .reset_n(reset_n), .motion(mo),
		.slow(slow), .standstill(still), .step_done(sdone));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(int k = 1);
		repeat (k) @(posedge clock);
		#1;
	endtask
	// one bus access; the shadow model predicts every read
	task automatic access(logic w, logic [15:0] a, logic [31:0] d, logic e);
		req = '{w, !w, a, d};
		tick();
		req = '0;
		check("ack", {rsp.ack, rsp.err}, {1'b1, e});
		if (w && !e)
			shadow[a] = d;
		if (!w)
			check("rdata", rsp.rdata, shadow[a]);
		tick();
	endtask
	task automatic wait_move(logic m, int lim);
		n = 0;
		while (mo.move !== m && n < lim) begin
			tick();
			n++;
		end
	endtask
	task automatic power_cycle(logic [3:0] p);
		pins = 4'h0;
		tick(3);
		pins = p;
		tick(4);
	endtask
	task automatic print_verdict();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		seed = 53;
		{fb, bpe, ds4, hlt, qs, err, slow} = '0;
		{pins, sw_in, req} = '0;
		reset_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 reset_n = 1'b1;
		tick();
		shadow = '{32'h1b00:0, 32'h1b04:0, 32'h1b06:0, 32'h1b08:20, 32'h1b0a:500,
			32'h1b0c:0, 32'h1b0e:0, 32'h1b10:32'h0000_4321, 32'h1b12:0};
		foreach (shadow[a]) access(1'b0, 16'(a), 32'h0, 1'b0);
		access(1'b1, JMS_ADDR_JOG_REQUEST, 32'h0000_0008, 1'b1);
		access(1'b1, JMS_ADDR_STEP_PAUSE_TIME, 32'h0000_0000, 1'b1);
		access(1'b1, JMS_ADDR_STEP_PAUSE_TIME, 32'h0000_8000, 1'b1);
		access(1'b1, JMS_ADDR_INPUT_JOG_METH, 32'h0000_0002, 1'b1);
		access(1'b1, 16'h1b16, 32'h0000_0001, 1'b1);
		ds4 = 1'b1;
		access(1'b1, JMS_ADDR_POS_CHG_TYPE, 32'h0000_0001, 1'b1);
		ds4 = 1'b0;
		for (i = 0; i < 4; i++) begin
			access(1'b1, JMS_ADDR_JOG_REQUEST, 32'($random(seed) & 7), 1'b0);
			access(1'b0, JMS_ADDR_JOG_REQUEST, 32'h0, 1'b0);
		end
		access(1'b1, JMS_ADDR_JOG_REQUEST, 32'h0, 1'b0);
		access(1'b1, JMS_ADDR_STEP_PAUSE_TIME, 32'h0000_0002, 1'b0);
		access(1'b1, JMS_ADDR_OPMODE_SELECT, 32'(JMS_MODE_JOG), 1'b0);
		// local control: enable pin starts the selected mode
		power_cycle(4'h1);
		check("started", {jact, pwr}, 2'b11);
		sw_in = 16'hffff;
		tick(2);
		check("status", sw, 16'heBff);
		pins = 4'h9;
		wait_move(1'b1, 10);
		tick(20);
		check("cont", {mo.move, mo.dir_neg, mo.step}, 3'b100);
		pins = 4'hd;
		wait_move(1'b0, 10);
		check("both", mo.move, 1'b0);
		pins = 4'h3;
		tick();
		check("fault", frst, 1'b1);
		pins = 4'h1;
		tick(20);
		access(1'b1, JMS_ADDR_INPUT_JOG_METH, 32'h0000_0001, 1'b0);
		power_cycle(4'h1);
		pins = 4'h5;
		tick();
		pins = 4'h1;
		wait_move(1'b1, 10);
		check("step", {mo.step, mo.dir_neg, mo.distance}, {2'b11, 32'd20});
		tick(2);
		check("held", mo.move, 1'b1);
		wait_move(1'b0, 20);
		tick(20);
		check("stepstop", mo.move, 1'b0);
		power_cycle(4'h9);
		wait_move(1'b1, 10);
		wait_move(1'b0, 20);
		wait_move(1'b1, 40);
		check("pause", {n >= 8 && n <= 12, mo.step}, 2'b10);
		pins = 4'h1;
		wait_move(1'b0, 10);
		check("halt", mo.halt, 1'b1);
		tick(20);
		access(1'b1, JMS_ADDR_INPUT_MAP, 32'h0000_4371, 1'b0);
		power_cycle(4'h1);
		check("noauto", jact, 1'b0);
		pins = 4'h3;
		tick();
		check("act", jact, 1'b1);
		// fieldbus control with a slow motion stage
		{fb, bpe, slow, pins} = {3'b111, 4'h0};
		access(1'b1, JMS_ADDR_BUS_JOG_METH, 32'h0, 1'b0);
		access(1'b1, JMS_ADDR_OPMODE_SELECT, 32'(JMS_MODE_JOG), 1'b0);
		tick(4);
		check("mode", amode, JMS_MODE_JOG);
		access(1'b1, JMS_ADDR_JOG_REQUEST, 32'h0000_0005, 1'b0);
		wait_move(1'b1, 10);
		check("fast", {mo.dir_neg, mo.fast}, 2'b01);
		access(1'b1, JMS_ADDR_OPMODE_SELECT, 32'(JMS_MODE_PV), 1'b0);
		tick(2);
		check("pv", {amode, still}, {JMS_MODE_PV, 1'b0});
		access(1'b1, JMS_ADDR_OPMODE_SELECT, 32'(JMS_MODE_JOG), 1'b0);
		tick(60);
		check("tojog", amode, JMS_MODE_JOG);
		access(1'b1, JMS_ADDR_JOG_REQUEST, 32'h0000_0006, 1'b0);
		wait_move(1'b1, 40);
		hlt = 1'b1;
		wait_move(1'b0, 10);
		check("stop", mo.halt, 1'b1);
		{hlt, err} = 2'b01;
		tick(2);
		check("nopower", pwr, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
